// *** xicm_board_model.sv ***
/*
 * board around the cell array: resolves every pin from the cell drive,
 * the board drivers and the weak hold of the cell.
 * assumes a board driver is stronger than the cell's own driver.
 */
`timescale 1ns/1ns
module xicm_board_model #(
  parameter int NCELL = 160
) (
  input wire logic [NCELL-1:0] pin_out,
  input wire logic [NCELL-1:0] pin_oe,
  input wire logic [NCELL-1:0] pin_hold_en,
  input wire logic [NCELL-1:0] pin_hold_val,
  input wire logic [NCELL-1:0] ext_val,
  input wire logic [NCELL-1:0] ext_oe,
  output logic [NCELL-1:0] pin_in
);
  // =====
  // wire resolution
  always_comb begin
    for (int i = 0; i < NCELL; i++) begin
      if (ext_oe[i]) pin_in[i] = ext_val[i];
      else if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (pin_hold_en[i]) pin_in[i] = pin_hold_val[i];
      else pin_in[i] = ~pin_hold_val[i];
    end
  end
endmodule

// *** xicm_cell_array.sv ***
/*
 * array of crosspoint i/o cells: select multiplexers with neighbour
 * cascade, storage element, output options.
 * assumes pins are synchronous to clk and configuration is static.
 */
`timescale 1ns/1ns
`include "xicm_defines.svh"

// Operation
// - each select line takes its pin from either select source set
// - multiplexer may take neighbour outputs of cells n-2, n-1, n+1, n+2
// - cascaded neighbours give sixteen-way selection in one extra level
// - a neighbour input replaces the direct pin group at its position
// - neighbour outputs feed multiplexers directly, not via routing pool
// - B19-B0, A, D39-D20 normal; B20-B39, C, D0-D19 reflected
// - reflected cell: positions A-D take n+2, n+1, n-1, n-2
// - normal cell: positions A-D take n-2, n-1, n+1, n+2
// - neighbour indexing wraps circularly across orientation boundaries
// - D23 using D21 loses direct group A input
// - one storage element, latch or register, input or output or bypassed
// - output path: storage fed by select multiplexer, drives the pin
// - input path: storage fed by pin, output feeds routing pool
// - storage clock from clock pin set or dedicated pin, polarity per cell
// - clock gate from clock pin set or global gate, polarity per cell
// - combinational bit routes multiplexer output straight to the pin
// - output polarity active high or active low
// - open-drain option only pulls low or releases
// - bus-hold weakly keeps last level when all drivers are off
// - fixed-level mode drives constant high or low, no input needed
// - static paths are fixed by configuration and independent
// - select code 00, 01, 11, 10 picks inputs 0, 1, 2, 3
// - gate low after polarity: register ignores clock edges
// - each output enable from enable pin set, polarity per cell, forced on in fixed-level mode
module xicm_cell_array #(
  parameter int NCELL = 160
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire xicm_pkg::xicm_cell_cfg_t cfg [NCELL],
  input wire logic [NCELL-1:0] pin_in,
  input wire logic [`XICM_NDED-1:0] ded_clk,
  input wire logic [`XICM_NDED-1:0] global_clock_gate,
  output logic [NCELL-1:0] pin_out,
  output logic [NCELL-1:0] pin_oe,
  output logic [NCELL-1:0] pin_hold_en,
  output logic [NCELL-1:0] pin_hold_val,
  output logic [NCELL-1:0] global_routing_pool,
  output logic [NCELL-1:0] neighbour_select_out
);
  import xicm_pkg::*;

  localparam int QTR = NCELL / 4;

  // =============================================
  // helper functions
  function automatic int pin_at(input int qtr, input int idx);
    pin_at = qtr * QTR + (idx % QTR);
  endfunction

  // select code to data input number
  function automatic logic [1:0] sel_code(input logic hi, input logic lo);
    sel_code = {hi, hi ^ lo};
  endfunction

  function automatic logic is_refl(input int n);
    int g;
    int i;
    g = n / QTR;
    i = n % QTR;
    is_refl = 1'b0;
    if (g == `XICM_GRP_B) begin
      is_refl = (i >= QTR / 2);
    end else if (g == `XICM_GRP_C) begin
      is_refl = 1'b1;
    end else if (g == `XICM_GRP_D) begin
      is_refl = (i < QTR / 2);
    end
  endfunction

  // neighbour feeding data position p of cell n
  function automatic int nb_of(input int n, input int p);
    int off;
    off = (p < 2) ? p - 2 : p - 1;
    if (is_refl(n)) begin
      off = -off;
    end
    nb_of = (n + off + NCELL) % NCELL;
  endfunction

  // =============================================
  // state
  logic [NCELL-1:0] store_reg, store_next;
  logic [NCELL-1:0] clkprev_reg, clkprev_next;
  logic [NCELL-1:0] keep_reg, keep_next;

  logic [NCELL-1:0] clk_lvl, gate_lvl, rise, q_in, oe_lvl;
  logic [NCELL-1:0] d, q, val;
  logic [NCELL-1:0][1:0] code;
  logic [NCELL-1:0][3:0] data;

  always_comb begin
    for (int n = 0; n < NCELL; n++) begin
      if (cfg[n].clk_ded) begin
        clk_lvl[n] = ded_clk[cfg[n].ded_idx] ^ cfg[n].clk_pol;
      end else begin
        clk_lvl[n] = pin_in[pin_at(`XICM_QTR_CLK, int'(cfg[n].clk_idx))]
                     ^ cfg[n].clk_pol;
      end
      if (cfg[n].gate_glob) begin
        gate_lvl[n] = global_clock_gate[cfg[n].glob_idx]
                      ^ cfg[n].gate_pol;
      end else begin
        gate_lvl[n] = pin_in[pin_at(`XICM_QTR_CLK, int'(cfg[n].gate_idx))]
                      ^ cfg[n].gate_pol;
      end
      rise[n] = clk_lvl[n] & ~clkprev_reg[n];
      // latch passes while clock active, otherwise the held value
      q_in[n] = (cfg[n].latch & clk_lvl[n]) ? pin_in[n] : store_reg[n];
      global_routing_pool[n] = (cfg[n].path == XICM_PATH_IN) ?
                               q_in[n] : pin_in[n];
    end
    // first level: direct pins only, so cascades never loop
    for (int n = 0; n < NCELL; n++) begin
      for (int s = 0; s < 2; s++) begin
        code[n][s] = pin_in[pin_at(cfg[n].sel_set[s] ? `XICM_QTR_SEL2 :
                     `XICM_QTR_SEL1, int'(cfg[n].sel_idx[s]))]
                     ^ cfg[n].sel_pol[s];
      end
      code[n] = sel_code(code[n][1], code[n][0]);
      neighbour_select_out[n] = global_routing_pool[pin_at(int'(code[n]),
                                int'(cfg[n].dir_idx[code[n]]))];
    end
    // second level: neighbour or direct pin group at each position
    for (int n = 0; n < NCELL; n++) begin
      for (int p = 0; p < 4; p++) begin
        if (cfg[n].use_nb[p]) begin
          data[n][p] = neighbour_select_out[nb_of(n, p)];
        end else begin
          data[n][p] = global_routing_pool[pin_at(p,
                       int'(cfg[n].dir_idx[p]))];
        end
      end
      d[n] = (cfg[n].path == XICM_PATH_IN) ? pin_in[n] :
             data[n][code[n]];
      q[n] = (cfg[n].latch & clk_lvl[n]) ? d[n] : store_reg[n];
      store_next[n] = store_reg[n];
      if (cfg[n].path != XICM_PATH_BYPASS) begin
        if (cfg[n].latch) begin
          if (clk_lvl[n]) begin
            store_next[n] = d[n];
          end
        end else if (rise[n] & gate_lvl[n]) begin
          store_next[n] = d[n];
        end
      end
      clkprev_next[n] = clk_lvl[n];
      keep_next[n] = pin_in[n];
      if (cfg[n].path == XICM_PATH_OUT && !cfg[n].comb) begin
        val[n] = q[n] ^ cfg[n].out_pol;
      end else begin
        val[n] = data[n][code[n]] ^ cfg[n].out_pol;
      end
      oe_lvl[n] = pin_in[pin_at(`XICM_QTR_OE, int'(cfg[n].oe_idx))]
                  ^ cfg[n].oe_pol;
      if (cfg[n].fixed_en) begin
        pin_out[n] = cfg[n].fixed_val;
        pin_oe[n] = 1'b1;
      end else if (cfg[n].open_drain) begin
        pin_out[n] = 1'b0;
        pin_oe[n] = oe_lvl[n] & ~val[n];
      end else begin
        pin_out[n] = val[n];
        pin_oe[n] = oe_lvl[n];
      end
      pin_hold_en[n] = cfg[n].bus_hold;
      pin_hold_val[n] = keep_reg[n];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      store_reg <= '0;
      clkprev_reg <= '0;
      keep_reg <= '0;
    end else begin
      store_reg <= store_next;
      clkprev_reg <= clkprev_next;
      keep_reg <= keep_next;
    end
  end

  // =============================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  for (genvar g = 0; g < NCELL; g++) begin : g_chk
    a_fixed_level_drive: assert property (
      cfg[g].fixed_en |-> pin_oe[g] && pin_out[g] == cfg[g].fixed_val)
      else $error("fixed level not driven");
    a_open_drain_low: assert property (
      cfg[g].open_drain && !cfg[g].fixed_en |-> !pin_out[g]
        && (pin_oe[g] == (oe_lvl[g] && !val[g])))
      else $error("open drain drove high");
    a_reg_gate_hold: assert property (
      !cfg[g].latch && !gate_lvl[g] && $stable(cfg[g])
        |=> $stable(store_reg[g]))
      else $error("register moved while gated");
    a_reg_edge_load: assert property (
      !cfg[g].latch && cfg[g].path != XICM_PATH_BYPASS && rise[g]
        && gate_lvl[g] |=> store_reg[g] == $past(d[g]))
      else $error("register missed an edge");
    a_latch_pass: assert property (
      cfg[g].latch && clk_lvl[g] |-> q[g] == d[g])
      else $error("latch not transparent");
    a_comb_bypass: assert property (
      cfg[g].comb && !cfg[g].fixed_en && !cfg[g].open_drain
        |-> pin_out[g] == (data[g][code[g]] ^ cfg[g].out_pol))
      else $error("bypass path wrong");
    a_input_path_pool: assert property (
      cfg[g].path == XICM_PATH_IN |-> global_routing_pool[g] == q_in[g])
      else $error("input path not in pool");
    a_select_code_two: assert property (
      code[g] == 2'h2 |-> d[g] == data[g][2]
        || cfg[g].path == XICM_PATH_IN)
      else $error("select code misdecoded");
    a_neighbour_pick: assert property (
      cfg[g].use_nb[0] && !is_refl(g)
        |-> data[g][0] == neighbour_select_out[(g + NCELL - 2) % NCELL])
      else $error("wrong neighbour at position a");
  end

  c_reg_load: cover property (rise[0] && gate_lvl[0] && !cfg[0].latch);
  c_neighbour_use: cover property (cfg[0].use_nb[3] && code[0] == 2'h3);
  c_open_drain_rel: cover property (cfg[1].open_drain && !pin_oe[1]);
  c_fixed_out: cover property (cfg[2].fixed_en);
endmodule

// *** xicm_cell_array_tb.sv ***
/*
 * testbench of the cell array: loads a cell, and its neighbour in the neighbour test, drives the board pins
 * and checks the cell outputs.
 * assumes xicm_board_model resolves the pins.
 */
`timescale 1ns/1ns
module xicm_cell_array_tb;
  import xicm_pkg::*;
  logic clk, rst_b;
  xicm_cell_cfg_t cfg [160];
  logic [159:0] ext_val, ext_oe, pin_in, pin_out, pin_oe;
  logic [159:0] hold_en, hold_val, pool;
  logic [3:0] ded_clk, gate;
  int mismatches, cmp_count;
  localparam logic [1:0] code [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  localparam int cells [4] = '{143, 60, 0, 79};
  // clk, gate, data, expected, checked
  localparam logic [4:0] rg [7] = '{5'h0c, 5'h1f, 5'h0b, 5'h13, 5'h0b,
    5'h19, 5'h0d};
  // clock, data, expected
  localparam logic [2:0] lt [4] = '{3'h7, 3'h1, 3'h4, 3'h2};

  always #10 clk = ~clk;

  xicm_cell_array u_dut (.clk(clk), .rst_b(rst_b), .cfg(cfg),
    .pin_in(pin_in), .ded_clk(ded_clk), .global_clock_gate(gate),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_hold_en(hold_en),
    .pin_hold_val(hold_val), .global_routing_pool(pool),
    .neighbour_select_out());
  xicm_board_model u_board (.pin_out(pin_out), .pin_oe(pin_oe),
    .pin_hold_en(hold_en), .pin_hold_val(hold_val), .ext_val(ext_val),
    .ext_oe(ext_oe), .pin_in(pin_in));

  // =====
  // tasks
  task automatic check(input logic seen, input logic exp, input string w);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", w, exp, seen);
    end
  endtask

  task automatic apply(input int c, input xicm_cell_cfg_t cc, input int n,
      input xicm_cell_cfg_t nc, input logic [159:0] pv,
      input logic [1:0] cg);
    @(posedge clk);
    foreach (cfg[i])
      cfg[i] <= (i == c) ? cc : (i == n) ? nc : xicm_cell_cfg_t'(0);
    ext_val <= pv;
    ded_clk <= {4{cg[1]}};
    gate <= {4{cg[0]}};
    #2;
  endtask

  function automatic int nbr(input int c, input int p);
    int k;
    int off;
    bit refl;
    k = c % 40;
    refl = c / 40 == 2 || (c / 40 == 1 && k > 19) || (c / 40 == 3 && k < 20);
    off = (p < 2) ? p - 2 : p - 1;
    if (refl) off = -off;
    return (c + off + 160) % 160;
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // =====
  // tests
  initial begin
    xicm_cell_cfg_t cc, nc;
    logic [159:0] pv;
    logic seen;
    clk = 0;
    rst_b = 0;
    ext_oe = '1;
    ext_val = '0;
    ded_clk = '0;
    gate = '0;
    foreach (cfg[i]) cfg[i] = '0;
    mismatches = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    cc = '0;
    cc.sel_idx = {6'h02, 6'h01};
    cc.dir_idx = {4{6'h07}};
    for (int s = 0; s < 2; s++) for (int p = 0; p < 4; p++) begin
      cc.sel_set = {s[0], s[0]};
      pv = '0;
      pv[p * 40 + 7] = 1'b1;
      {pv[82 + 40 * s], pv[81 + 40 * s]} = code[p];
      {pv[122 - 40 * s], pv[121 - 40 * s]} = code[(p + 2) % 4];
      apply(143, cc, 143, cc, pv, 2'h0);
      check(pin_out[143], 1'b1, "select");
    end
    $display("test select done");
    cc.sel_set = 2'h0;
    nc = '0;
    nc.dir_idx[0] = 6'h09;
    foreach (cells[j]) for (int p = 0; p < 8; p++) begin
      cc.use_nb = 4'h1 << (p / 2);
      pv = '0;
      pv[9] = p[0];
      {pv[0], pv[7], pv[47], pv[87], pv[127]} = {5{~p[0]}};
      {pv[82], pv[81]} = code[p / 2];
      apply(cells[j], cc, nbr(cells[j], p / 2), nc, pv, 2'h0);
      check(pin_out[cells[j]], p[0], "neighbour");
    end
    $display("test neighbour done");
    cc.use_nb = 4'h0;
    cc.oe_pol = 1'b1;
    for (int v = 0; v < 2; v++) begin
      pv = '0;
      pv[7] = v[0];
      cc.out_pol = 1'b1;
      apply(143, cc, 143, cc, pv, 2'h0);
      check(pin_out[143], ~v[0], "polarity");
      check(pin_oe[143], 1'b1, "enable");
      cc.out_pol = 1'b0;
      cc.open_drain = 1'b1;
      apply(143, cc, 143, cc, pv, 2'h0);
      check(pin_oe[143], ~v[0], "open drain");
      if (v == 0) check(pin_out[143], 1'b0, "drain level");
      cc.fixed_en = 1'b1;
      cc.fixed_val = ~v[0];
      apply(143, cc, 143, cc, pv, 2'h0);
      check(pin_out[143], ~v[0], "fixed level");
      check(pin_oe[143], 1'b1, "fixed enable");
      {cc.open_drain, cc.fixed_en} = 2'h0;
    end
    $display("test output options done");
    cc.clk_idx = 6'h03;
    cc.gate_glob = 1'b1;
    cc.glob_idx = 2'h1;
    for (int m = 0; m < 2; m++) begin
      cc.path = m ? XICM_PATH_IN : XICM_PATH_OUT;
      foreach (rg[k]) begin
        pv = '0;
        pv[43] = rg[k][4];
        pv[m ? 143 : 7] = rg[k][2];
        apply(143, cc, 143, cc, pv, {1'b0, rg[k][3]});
        @(posedge clk);
        #2;
        seen = m ? pool[143] : pin_out[143];
        if (rg[k][0])
          check(seen, rg[k][1], "store");
      end
    end
    cc.path = XICM_PATH_OUT;
    cc.comb = 1'b1;
    pv = '0;
    pv[7] = 1'b1;
    apply(143, cc, 143, cc, pv, 2'h0);
    check(pin_out[143], 1'b1, "comb bypass");
    {cc.comb, cc.latch, cc.clk_ded, cc.ded_idx} = 5'h0e;
    foreach (lt[k]) begin
      pv[7] = lt[k][1];
      apply(143, cc, 143, cc, pv, {lt[k][2], 1'b0});
      check(pin_out[143], lt[k][0], "latch");
    end
    $display("test storage done");
    cc = '0;
    cc.dir_idx = {4{6'h07}};
    {cc.open_drain, cc.bus_hold} = 2'h3;
    pv[143] = 1'b1;
    apply(143, cc, 143, cc, pv, 2'h0);
    @(posedge clk);
    ext_oe[143] <= 1'b0;
    repeat (3) @(posedge clk);
    #2;
    check(hold_en[143], 1'b1, "hold enable");
    check(hold_val[143], 1'b1, "hold level");
    check(pin_in[143], 1'b1, "held pin");
    $display("test bus hold done");
    print_verdict();
  end
endmodule

// *** xicm_defines.svh ***
/*
 * constant names for the crosspoint i/o cell multiplexer
 * assumes it is included by xicm_pkg and the cell array module
 */
`ifndef XICM_DEFINES_SVH
`define XICM_DEFINES_SVH

// =============================================
// field widths
`define XICM_IDX_W 6
`define XICM_SELW 2
`define XICM_NDED 4

// =============================================
// quarter of the pins that serves each control set
`define XICM_QTR_OE 0
`define XICM_QTR_CLK 1
`define XICM_QTR_SEL1 2
`define XICM_QTR_SEL2 3

// =============================================
// die groups of cells
`define XICM_GRP_A 0
`define XICM_GRP_B 1
`define XICM_GRP_C 2
`define XICM_GRP_D 3

`endif

// *** xicm_pkg.sv ***
/*
 * types of the crosspoint i/o cell multiplexer
 * assumes xicm_defines.svh is on the include path
 */
`include "xicm_defines.svh"

package xicm_pkg;

  // =============================================
  // storage element placement
  typedef enum logic [1:0] {
    XICM_PATH_BYPASS = 2'h0,
    XICM_PATH_IN = 2'h1,
    XICM_PATH_OUT = 2'h3
  } xicm_path_t;

  // =============================================
  // one cell's non-volatile configuration
  typedef struct packed {
    logic [1:0] sel_set;
    logic [1:0][`XICM_IDX_W-1:0] sel_idx;
    logic [1:0] sel_pol;
    logic [3:0] use_nb;
    logic [3:0][`XICM_IDX_W-1:0] dir_idx;
    xicm_path_t path;
    logic latch;
    logic comb;
    logic clk_ded;
    logic [`XICM_IDX_W-1:0] clk_idx;
    logic [1:0] ded_idx;
    logic clk_pol;
    logic gate_glob;
    logic [`XICM_IDX_W-1:0] gate_idx;
    logic [1:0] glob_idx;
    logic gate_pol;
    logic [`XICM_IDX_W-1:0] oe_idx;
    logic oe_pol;
    logic out_pol;
    logic open_drain;
    logic bus_hold;
    logic fixed_en;
    logic fixed_val;
  } xicm_cell_cfg_t;

endpackage
